// ===== hdl/rss_strap_sampler.sv
// Reset strap sampler: catches the strap pins at reset release, then drives them.
`timescale 1ns/1ps
module rss_strap_sampler
    import rss_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Strap pins, each as input, output, output enable and pulldown enable.
    input  wire logic        test_strap_three_in,
    output logic             test_strap_three_out,
    output logic             test_strap_three_oe,
    output logic             test_strap_three_pd,
    input  wire logic        flash_boot_strap_in,
    output logic             flash_boot_strap_out,
    output logic             flash_boot_strap_oe,
    output logic             flash_boot_strap_pd,
    input  wire logic        test_strap_five_in,
    output logic             test_strap_five_out,
    output logic             test_strap_five_oe,
    output logic             test_strap_five_pd,
    input  wire logic        clock_select_strap_in,
    output logic             clock_select_strap_out,
    output logic             clock_select_strap_oe,
    output logic             clock_select_strap_pd,
    // Configuration results.
    output logic             straps_valid,
    output logic             autoinit_start,
    output logic             autoinit_enable,
    output logic             i2c_flash_prog_mode,
    output logic             pll_ref_select,
    output logic      [15:0] pll_ref_khz,
    output logic             test_mode
);

    // Pin order inside the packed vectors: 0 three, 1 flash, 2 five, 3 clock.
    logic [3:0] pins_sync;
    logic [1:0] cnt_q;
    logic       done_q;
    logic [3:0] strap_q;
    logic       auto_pulse_q;
    logic       focus_en_q;
    logic [RSS_FOCUS_W-1:0]   focus_q;
    logic [RSS_TESTOUT_W-1:0] testout_q;
    logic [3:0] pin_out_q;
    logic [3:0] pin_out_d;
    logic       ack_q;
    logic       req;
    logic       wr_go;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // The pins are asynchronous, so they pass the synchroniser first.
    rss_sync #(
        .WIDTH    (4)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({clock_select_strap_in, test_strap_five_in,
                    flash_boot_strap_in, test_strap_three_in}),
        .sync_out (pins_sync)
    );

    // The internal pulldowns are always on; a floating pin reads low.
    assign test_strap_three_pd   = 1'b1;
    assign flash_boot_strap_pd   = 1'b1;
    assign test_strap_five_pd    = 1'b1;
    assign clock_select_strap_pd = 1'b1;

    // Count edges after reset release until the synchroniser holds real pin
    // levels; capturing earlier would catch the flops' reset zeros.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
        end else if (!done_q && cnt_q != RSS_CAPTURE_CNT) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // Straps are taken once, then frozen until the chip reset returns.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_q  <= 1'b0;
            strap_q <= 4'h0;
        end else if (!done_q && cnt_q == RSS_CAPTURE_CNT) begin
            done_q  <= 1'b1;
            strap_q <= pins_sync;
        end
    end

    // A low flash strap launches auto-initialisation with a single pulse.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            auto_pulse_q <= 1'b0;
        end else begin
            auto_pulse_q <= !done_q && cnt_q == RSS_CAPTURE_CNT
                            && !pins_sync[1];
        end
    end

    assign straps_valid        = done_q;
    assign autoinit_start      = auto_pulse_q;
    // Both levels stay low until the straps are known.
    assign autoinit_enable     = done_q && !strap_q[1];
    assign i2c_flash_prog_mode = done_q && strap_q[1];
    assign pll_ref_select      = strap_q[3];
    assign pll_ref_khz = strap_q[3] ? RSS_REF_HIGH_KHZ
                                    : RSS_REF_LOW_KHZ;
    // Only the test-only pins can force a test mode.
    assign test_mode = strap_q[0] | strap_q[2];

    // Pin drive values: focus data replaces the test outputs on pins three
    // and flash when the motor is in use.
    always_comb begin
        pin_out_d = testout_q;
        if (focus_en_q) begin
            pin_out_d[0] = focus_q[RSS_FOCUS_BIT3];
            pin_out_d[1] = focus_q[RSS_FOCUS_BIT4];
        end
    end

    // Drive values come from flops so the pins never glitch.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_out_q <= 4'h0;
        end else begin
            pin_out_q <= pin_out_d;
        end
    end

    assign test_strap_three_out   = pin_out_q[0];
    assign flash_boot_strap_out   = pin_out_q[1];
    assign test_strap_five_out    = pin_out_q[2];
    assign clock_select_strap_out = pin_out_q[3];
    // Pins only drive once they have been sampled.
    assign test_strap_three_oe    = done_q;
    assign flash_boot_strap_oe    = done_q;
    assign test_strap_five_oe     = done_q;
    assign clock_select_strap_oe  = done_q;

    // Every access waits one cycle: waitrequest falls in the second cycle.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & !ack_q;
    assign wr_go           = avs_write & ack_q & avs_byteenable[0];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & !ack_q;
        end
    end

    // Software registers; all fields live in byte lane 0.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            focus_en_q <= RSS_CTRL_RST;
            focus_q    <= RSS_FOCUS_RST;
            testout_q  <= RSS_TESTOUT_RST;
        end else if (wr_go) begin
            unique case (avs_address)
                RSS_CTRL_OFS: begin
                    focus_en_q <= avs_writedata[RSS_CTRL_FOCUS_BIT];
                end
                RSS_FOCUS_OFS: begin
                    focus_q <= avs_writedata[RSS_FOCUS_W-1:0];
                end
                RSS_TESTOUT_OFS: begin
                    testout_q <= avs_writedata[RSS_TESTOUT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero, reserved bits read zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            RSS_CTRL_OFS: begin
                rdata_d[RSS_CTRL_FOCUS_BIT] = focus_en_q;
            end
            RSS_FOCUS_OFS: begin
                rdata_d[RSS_FOCUS_W-1:0] = focus_q;
            end
            RSS_TESTOUT_OFS: begin
                rdata_d[RSS_TESTOUT_W-1:0] = testout_q;
            end
            RSS_STATUS_OFS: begin
                rdata_d[RSS_ST_DONE_BIT]   = done_q;
                rdata_d[RSS_ST_FLASH_BIT]  = strap_q[1];
                rdata_d[RSS_ST_CLKSEL_BIT] = strap_q[3];
                rdata_d[RSS_ST_THREE_BIT]  = strap_q[0];
                rdata_d[RSS_ST_FIVE_BIT]   = strap_q[2];
                rdata_d[RSS_ST_TEST_BIT]   = test_mode;
                rdata_d[RSS_ST_AUTO_BIT]   = autoinit_enable;
            end
            default: begin
            end
        endcase
    end

    // Read data is loaded in the waiting cycle and stands in the answer cycle.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read & !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;

    // Checks.
    logic [2:0] since_rel_q;

    // Helper: edges since reset release, saturating.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            since_rel_q <= 3'h0;
        end else if (since_rel_q != 3'h7) begin
            since_rel_q <= since_rel_q + 3'h1;
        end
    end

    sequence s_settle;
        !done_q [*3];
    endsequence

    sequence s_captured;
        done_q && test_strap_three_oe && clock_select_strap_oe;
    endsequence

    a_capture_moment: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (since_rel_q == 3'h3) |-> s_captured)
        else $error("straps not captured on the third edge");

    a_oe_before_capture: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (since_rel_q == 3'h0) |-> s_settle ##1 s_captured)
        else $error("pins driven before strap capture");

    a_pulldown_on: assert property (
        @(posedge core_clk) disable iff (!rstn)
        test_strap_three_pd && flash_boot_strap_pd
        && test_strap_five_pd && clock_select_strap_pd)
        else $error("internal pulldown released");

    a_autoinit_pulse: assert property (
        @(posedge core_clk) disable iff (!rstn)
        $rose(done_q) |-> (autoinit_start == !strap_q[1])
        ##1 !autoinit_start [*3])
        else $error("auto-init pulse wrong");

    a_boot_modes: assert property (
        @(posedge core_clk) disable iff (!rstn)
        done_q |-> (autoinit_enable != i2c_flash_prog_mode)
        && (i2c_flash_prog_mode == strap_q[1]))
        else $error("boot mode does not follow flash strap");

    a_clk_capture: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (!done_q && cnt_q == RSS_CAPTURE_CNT)
        |=> pll_ref_select == $past(pins_sync[3]))
        else $error("clock strap not taken at capture");

    a_ref_freq: assert property (
        @(posedge core_clk) disable iff (!rstn)
        pll_ref_khz == (pll_ref_select ? 16'h208A : 16'h411E))
        else $error("reference frequency mismatch");

    a_focus_bit3: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (focus_en_q && $stable(focus_q) && $stable(focus_en_q))
        |=> test_strap_three_out == $past(focus_q[RSS_FOCUS_BIT3]))
        else $error("pin three lost focus bit 3");

    a_focus_bit4: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (focus_en_q && $stable(focus_q) && $stable(focus_en_q))
        |=> flash_boot_strap_out == $past(focus_q[RSS_FOCUS_BIT4]))
        else $error("flash pin lost focus bit 4");

    a_strap_hold: assert property (
        @(posedge core_clk) disable iff (!rstn)
        done_q |=> done_q && $stable(strap_q))
        else $error("captured straps changed");

    a_bus_answer: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (req && !ack_q) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
        else $error("bus answer not in second cycle");

endmodule

// ===== pkg/rss_pkg.sv
// Constants shared by the reset strap sampler design files.
package rss_pkg;

    // Register byte offsets on the Avalon-MM slave port.
    localparam logic [3:0] RSS_CTRL_OFS     = 4'h0;
    localparam logic [3:0] RSS_FOCUS_OFS    = 4'h4;
    localparam logic [3:0] RSS_TESTOUT_OFS  = 4'h8;
    localparam logic [3:0] RSS_STATUS_OFS   = 4'hC;

    // Control register field positions.
    localparam int RSS_CTRL_FOCUS_BIT = 0;

    // Focus motor data word layout.
    localparam int RSS_FOCUS_W       = 5;
    localparam int RSS_FOCUS_BIT3    = 3;
    localparam int RSS_FOCUS_BIT4    = 4;

    // Test output register width, one bit per strap pin.
    localparam int RSS_TESTOUT_W = 4;

    // Status register field positions.
    localparam int RSS_ST_DONE_BIT   = 0;
    localparam int RSS_ST_FLASH_BIT  = 1;
    localparam int RSS_ST_CLKSEL_BIT = 2;
    localparam int RSS_ST_THREE_BIT  = 3;
    localparam int RSS_ST_FIVE_BIT   = 4;
    localparam int RSS_ST_TEST_BIT   = 5;
    localparam int RSS_ST_AUTO_BIT   = 6;

    // Reset values of the software registers.
    localparam logic                     RSS_CTRL_RST    = 1'b0;
    localparam logic [RSS_FOCUS_W-1:0]   RSS_FOCUS_RST   = 5'h00;
    localparam logic [RSS_TESTOUT_W-1:0] RSS_TESTOUT_RST = 4'h0;

    // Strap pin synchroniser depth and the count at which straps are taken.
    localparam int         RSS_SYNC_STAGES = 2;
    localparam logic [1:0] RSS_CAPTURE_CNT = 2'h2;

    // Reference clock frequencies assumed by the PLL, in kHz.
    localparam logic [15:0] RSS_REF_LOW_KHZ  = 16'h411E;
    localparam logic [15:0] RSS_REF_HIGH_KHZ = 16'h208A;

endpackage

// ===== hdl/rss_sync.sv
// Two-flop synchroniser bank for the asynchronous strap pins.
`timescale 1ns/1ps
module rss_sync
    import rss_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] hold_q;

    // Each pin gets its own pair of flops; the first is read only by the
    // second, so metastability never reaches the capture logic.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q[i] <= 1'b0;
                    hold_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    hold_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = hold_q;

endmodule

// ===== bench/rss_board.sv
// Board model: strap resistors and the focus motor driver inputs.
`timescale 1ns/1ps
module rss_board (
    input  wire logic [3:0] pullup_fit,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] pin_pd,
    output logic      [3:0] pin_lvl,
    output logic      [1:0] motor_hi
);
    // A driven pin wins, then a fitted pullup, then the weak pulldown.
    // No external logic fights the pulldown here, so none is added.
    // An undriven pin without a pullup reads high when its pulldown is off, so a missing pulldown is seen at once.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (pullup_fit[i]) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = ~pin_pd[i];
            end
        end
    end
    // The motor driver takes data bits 4 and 3 from the flash and three pins.
    assign motor_hi = {pin_lvl[1], pin_lvl[0]};
endmodule

// ===== bench/tb.sv
// Self-checking bench for the reset strap sampler.
`timescale 1ns/1ps
module tb;
    import rss_pkg::*;
    logic        core_clk, rstn, avs_read, avs_write;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        avs_waitrequest, straps_valid, autoinit_start;
    logic        autoinit_enable, i2c_flash_prog_mode, pll_ref_select;
    logic        test_mode;
    logic [15:0] pll_ref_khz;
    logic [3:0]  pin_out, pin_oe, pin_pd, pin_lvl, pullup_fit;
    logic [1:0]  motor_hi;
    int          bad_count, checked;

    rss_strap_sampler u_rss_strap_sampler (
        .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .test_strap_three_in(pin_lvl[0]), .test_strap_three_out(pin_out[0]),
        .test_strap_three_oe(pin_oe[0]), .test_strap_three_pd(pin_pd[0]),
        .flash_boot_strap_in(pin_lvl[1]), .flash_boot_strap_out(pin_out[1]),
        .flash_boot_strap_oe(pin_oe[1]), .flash_boot_strap_pd(pin_pd[1]),
        .test_strap_five_in(pin_lvl[2]), .test_strap_five_out(pin_out[2]),
        .test_strap_five_oe(pin_oe[2]), .test_strap_five_pd(pin_pd[2]),
        .clock_select_strap_in(pin_lvl[3]),
        .clock_select_strap_out(pin_out[3]),
        .clock_select_strap_oe(pin_oe[3]), .clock_select_strap_pd(pin_pd[3]),
        .straps_valid(straps_valid), .autoinit_start(autoinit_start),
        .autoinit_enable(autoinit_enable),
        .i2c_flash_prog_mode(i2c_flash_prog_mode),
        .pll_ref_select(pll_ref_select), .pll_ref_khz(pll_ref_khz),
        .test_mode(test_mode));

    rss_board u_rss_board (.pullup_fit(pullup_fit), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pd(pin_pd), .pin_lvl(pin_lvl),
        .motor_hi(motor_hi));

    // Free-running 100 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Expected PLL reference in kHz: 16670 when low, 8330 when high.
    function automatic logic [15:0] exp_khz(input logic cs);
        return cs ? 16'h208A : 16'h411E;
    endfunction

    // Expected status word for a captured strap set.
    function automatic logic [31:0] exp_status(input logic [3:0] s);
        return {25'h0, ~s[1], s[0] | s[2], s[2], s[0], s[3], s[1], 1'b1};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon-MM access; the request holds until waitrequest is low.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        logic w;
        w = 1'b1;
        q = 32'h0;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        for (int i = 0; i < 20 && w; i++) begin
            @(negedge core_clk);
            w = avs_waitrequest;
            q = avs_readdata;
            @(posedge core_clk);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (w !== 1'b0) begin
            chk(32'(w), 32'h0);
            report_and_stop();
        end
    endtask

    // Resets with a strap set fitted and checks the capture moment.
    task automatic do_reset(input logic [3:0] s);
        int n;
        pullup_fit <= s;
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk({pin_oe, pin_out}, 32'h0);
        chk(pin_pd, 32'hF);
        chk({straps_valid, pll_ref_khz}, {15'h0, 1'b0, 16'h411E});
        @(posedge core_clk);
        rstn <= 1'b1;
        for (n = 1; n <= 8; n++) begin
            @(posedge core_clk);
            #1;
            if (straps_valid === 1'b1) break;
        end
        chk(32'(n), 32'h3);
        if (n > 8) report_and_stop();
        chk({autoinit_start, autoinit_enable, i2c_flash_prog_mode},
            {~s[1], ~s[1], s[1]});
        chk({pll_ref_select, pll_ref_khz}, {s[3], exp_khz(s[3])});
        chk({test_mode, pin_oe}, {s[0] | s[2], 4'hF});
        @(posedge core_clk);
        #1;
        chk(autoinit_start, 32'h0);
    endtask

    // Main sequence: every strap pattern, then random ones.
    initial begin
        logic [31:0] q;
        logic [3:0]  s, tw;
        logic [4:0]  fw;
        {rstn, avs_read, avs_write} = 3'h0;
        {avs_address, avs_byteenable, avs_writedata} = 40'h0;
        pullup_fit = 4'h0;
        void'($urandom(32'hBE5BB8FB));
        for (int k = 0; k < 24; k++) begin
            s  = (k < 16) ? 4'(k) : 4'($urandom());
            tw = 4'($urandom());
            fw = 5'($urandom());
            do_reset(s);
            bus(1'b0, RSS_STATUS_OFS, 32'h0, 4'hF, q);
            chk(q, exp_status(s));
            bus(1'b0, RSS_FOCUS_OFS, 32'h0, 4'hF, q);
            chk(q, 32'(RSS_FOCUS_RST));
            bus(1'b0, RSS_TESTOUT_OFS, 32'h0, 4'hF, q);
            chk(q, 32'(RSS_TESTOUT_RST));
            bus(1'b1, RSS_TESTOUT_OFS, 32'(tw), 4'h1, q);
            @(posedge core_clk);
            #1;
            chk(pin_lvl, 32'(tw));
            bus(1'b1, RSS_FOCUS_OFS, 32'(fw), 4'h1, q);
            bus(1'b1, RSS_CTRL_OFS, 32'h1, 4'h1, q);
            bus(1'b1, RSS_CTRL_OFS, 32'h0, 4'h0, q);
            bus(1'b0, RSS_CTRL_OFS, 32'h0, 4'hF, q);
            chk(q, 32'h1);
            @(posedge core_clk);
            #1;
            chk(pin_out, {tw[3], tw[2], fw[4], fw[3]});
            chk(motor_hi, 32'(fw[4:3]));
            pullup_fit <= ~s;
            bus(1'b1, RSS_STATUS_OFS, 32'h0, 4'hF, q);
            bus(1'b1, 4'h2, 32'hFF, 4'hF, q);
            bus(1'b0, 4'h2, 32'h0, 4'hF, q);
            chk(q, 32'h0);
            bus(1'b0, RSS_STATUS_OFS, 32'h0, 4'hF, q);
            chk(q, exp_status(s));
            chk(pll_ref_khz, 32'(exp_khz(s[3])));
            bus(1'b0, RSS_FOCUS_OFS, 32'h0, 4'hF, q);
            chk(q, 32'(fw));
        end
        report_and_stop();
    end
endmodule
